// *** core/hv_output_protection_control.sv ***
// per-channel setpoint control, ramping and latched protection
// assumes front-panel pins and shutdown pin are asynchronous; host commands are
// one-cycle strobes from a decoder on sys_clk; codes scale 1 V per count
`default_nettype none
// Notes on behaviour
// - over current trip latches output off
// - auto start resumes after status read
// - kill on: limit or shutdown latches off
// - kill latch cleared by switches or host
// - kill off: clamp to voltage limit instead
// - kill off: shutdown input forces zero
// - shutdown release returns via ramp
// - limits are tenths of full scale
// - error indicator when limit exceeded
// - manual ramp 500 volts per second
// - remote gives nothing before commands
// - stored auto start runs when setpoint nonzero
// - manual to remote keeps voltage
// - remote ramp 2 to 255 V/s
// - polarity between ends forces zero
// - front panel wins over software
// - manual mode ignores output writes
// - host writes setpoint, rate, trip, auto
// - remote setpoint is 16 bits
// - limits sampled several times per second
// - display picks voltage or current
// - trip field 10 uA counts, zero off
// - auto start reads 8 or 0
module hv_output_protection_control
    import hv_prot_pkg::*;
#(
    parameter int unsigned NCH = 2,
    parameter int unsigned LIMIT_SCAN = LIMIT_SCAN_CYC,
    // ramp timebase; a lower figure in simulation lets ramps move in few cycles
    parameter int unsigned CLK_FREQ_HZ = CLK_HZ,
    parameter logic [CODE_W-1:0] FULL_SCALE = 16'h0bb8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [NCH-1:0] output_on_switch,
    input wire logic [NCH-1:0] manual_sel,
    input wire logic [NCH-1:0] kill_enable,
    input wire logic [NCH-1:0] shutdown_n,
    input wire logic [NCH-1:0] pol_at_end,
    input wire logic [NCH*SEL_W-1:0] voltage_limit_selector,
    input wire logic [NCH*SEL_W-1:0] current_limit_selector,
    input wire logic [NCH*CODE_W-1:0] pot_setpoint,
    input wire logic [NCH*CODE_W-1:0] meas_voltage,
    input wire logic [NCH*CODE_W-1:0] meas_current,
    input wire logic meas_switch,
    input wire logic chan_switch,
    input wire logic stored_auto_start,
    input wire logic [NCH-1:0] cmd_set_voltage,
    input wire logic [NCH-1:0] cmd_set_rate,
    input wire logic [NCH-1:0] cmd_set_trip,
    input wire logic [NCH-1:0] cmd_set_auto,
    input wire logic [NCH-1:0] cmd_status_read,
    input wire logic [NCH-1:0] cmd_start,
    input wire logic [NCH-1:0] cmd_output_zero,
    input wire logic [CODE_W-1:0] cmd_data,
    output logic [NCH*CODE_W-1:0] dac_code,
    output logic [NCH-1:0] latched_off,
    output logic [NCH-1:0] trip_seen,
    output logic [NCH-1:0] error_led,
    output logic [NCH-1:0] inhibit_seen,
    output logic [NCH-1:0] ramp_up,
    output logic [NCH-1:0] ramp_down,
    output logic [NCH*4-1:0] auto_start_read,
    output logic [NCH*TRIP_W-1:0] trip_read,
    output logic [NCH*8-1:0] rate_read,
    output logic [CODE_W-1:0] display_value
);
    localparam int unsigned PIN_W = 5 * NCH + 2 * NCH * SEL_W + 2;
    localparam logic [31:0] SCAN_LAST = 32'(LIMIT_SCAN - 1);

    // tenths of full scale, saturating at position ten
    function automatic logic [CODE_W-1:0] tenth_scale(input logic [SEL_W-1:0] pos,
                                                       input logic [CODE_W-1:0] fs);
        logic [SEL_W-1:0] p;
        logic [CODE_W+SEL_W-1:0] prod;
        p = (pos > SEL_W'(SEL_FULL)) ? SEL_W'(SEL_FULL) : pos;
        prod = fs * p;
        return CODE_W'(prod / (CODE_W + SEL_W)'(SEL_FULL));
    endfunction

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    logic [NCH-1:0] on_s, man_s, kill_s, shd_n_s, pol_s;
    logic [NCH*SEL_W-1:0] vsel_s, isel_s;
    logic meas_s, chan_s;

    assign pin_raw = {output_on_switch, manual_sel, kill_enable, shutdown_n, pol_at_end,
                      voltage_limit_selector, current_limit_selector, meas_switch, chan_switch};

    sync2 #(.W(PIN_W)) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .async_in(pin_raw),
        .sync_out(pin_s)
    );

    assign {on_s, man_s, kill_s, shd_n_s, pol_s, vsel_s, isel_s, meas_s, chan_s} = pin_s;

    // limit selectors are re-sampled periodically like a slow scanner
    logic [31:0] scan_q;
    logic scan_tick;
    assign scan_tick = scan_q == SCAN_LAST;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scan_q <= 32'h0000_0000;
        end else if (scan_tick) begin
            scan_q <= 32'h0000_0000;
        end else begin
            scan_q <= scan_q + 32'h0000_0001;
        end
    end

    // startup auto start strap is caught after reset release
    logic boot_q;
    logic boot_auto_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            boot_q <= 1'b1;
            boot_auto_q <= 1'b0;
        end else begin
            boot_q <= 1'b0;
            if (boot_q) begin
                boot_auto_q <= stored_auto_start;
            end
        end
    end

    logic [NCH*CODE_W-1:0] level_all;

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_ch
            logic [CODE_W-1:0] vlim_q, ilim_q, set_q, pot, mv, mi, target, lvl;
            logic [TRIP_W-1:0] trip_q;
            logic [7:0] rate_q;
            logic auto_q, run_q, latch_q, trip_flag_q, inh_flag_q, wait_start_q;
            logic man_prev_q, on_prev_q, kill_prev_q;
            logic over_i, over_v, trip_hit, inh_now, kill_ev, hold_zero, load_en;
            logic to_remote, panel_clear, host_clear, auto_clear;
            logic [19:0] rate_cps;
            logic [CODE_W-1:0] trip_code;

            assign pot = pot_setpoint[c*CODE_W +: CODE_W];
            assign mv = meas_voltage[c*CODE_W +: CODE_W];
            assign mi = meas_current[c*CODE_W +: CODE_W];

            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    vlim_q <= '0;
                    ilim_q <= '0;
                end else if (scan_tick || boot_q) begin
                    vlim_q <= tenth_scale(vsel_s[c*SEL_W +: SEL_W], FULL_SCALE);
                    ilim_q <= tenth_scale(isel_s[c*SEL_W +: SEL_W], 16'hffff);
                end
            end

            // trip counts are 10 uA; measured current uses the same unit
            assign trip_code = CODE_W'(trip_q);
            assign trip_hit = (trip_q != TRIP_OFF) && (mi > trip_code);
            assign over_i = mi > ilim_q;
            assign over_v = mv > vlim_q;
            assign inh_now = !shd_n_s[c];
            assign kill_ev = kill_s[c] && (over_i || over_v || inh_now);
            assign to_remote = man_prev_q && !man_s[c];
            assign panel_clear = (on_s[c] && !on_prev_q) || (kill_s[c] != kill_prev_q);
            assign host_clear = wait_start_q && cmd_start[c] && !man_s[c];
            assign auto_clear = auto_q && cmd_status_read[c];

            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    man_prev_q <= 1'b0;
                    on_prev_q <= 1'b0;
                    kill_prev_q <= 1'b0;
                end else begin
                    man_prev_q <= man_s[c];
                    on_prev_q <= on_s[c];
                    kill_prev_q <= kill_s[c];
                end
            end

            // host writes only take effect under remote control
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    set_q <= '0;
                    rate_q <= RAMP_RST;
                    trip_q <= TRIP_OFF;
                    auto_q <= 1'b0;
                end else begin
                    if (boot_q) begin
                        auto_q <= stored_auto_start;
                    end else if (cmd_set_auto[c] && !man_s[c]) begin
                        auto_q <= cmd_data != 16'h0000;
                    end
                    if (to_remote) begin
                        set_q <= lvl;
                    end else if (cmd_set_voltage[c] && !man_s[c]) begin
                        set_q <= (cmd_data > vlim_q) ? vlim_q : cmd_data;
                    end
                    if (cmd_set_rate[c] && !man_s[c]) begin
                        rate_q <= (cmd_data < 16'(SW_RAMP_MIN)) ? 8'(SW_RAMP_MIN) :
                                  (cmd_data > 16'(SW_RAMP_MAX)) ? 8'(SW_RAMP_MAX) : cmd_data[7:0];
                    end
                    if (cmd_set_trip[c] && !man_s[c]) begin
                        trip_q <= (cmd_data > CODE_W'(TRIP_MAX)) ? TRIP_MAX : cmd_data[TRIP_W-1:0];
                    end
                end
            end

            // remote output runs after a start, a switch from manual, a status read with auto start set, or from stored auto start
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    run_q <= 1'b0;
                end else if (boot_q) begin
                    run_q <= 1'b0;
                end else if (boot_q == 1'b0 && boot_auto_q && !run_q && !latch_q && set_q != 16'h0000) begin
                    run_q <= 1'b1;
                end else if (man_s[c] || cmd_output_zero[c]) begin
                    run_q <= 1'b0;
                end else if (to_remote) begin
                    run_q <= 1'b1;
                end else if (cmd_start[c] && !latch_q) begin
                    run_q <= 1'b1;
                end else if (host_clear || auto_clear) begin
                    run_q <= 1'b1;
                end
            end

            // latch: new trip or kill event wins over any clear in the same cycle
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    latch_q <= 1'b0;
                    trip_flag_q <= 1'b0;
                    inh_flag_q <= 1'b0;
                    wait_start_q <= 1'b0;
                end else begin
                    if (trip_hit || kill_ev) begin
                        latch_q <= 1'b1;
                    end else if (panel_clear || host_clear || auto_clear) begin
                        latch_q <= 1'b0;
                    end
                    if (trip_hit) begin
                        trip_flag_q <= 1'b1;
                    end else if (cmd_status_read[c]) begin
                        trip_flag_q <= 1'b0;
                    end
                    if (inh_now) begin
                        inh_flag_q <= 1'b1;
                    end else if (cmd_status_read[c]) begin
                        inh_flag_q <= 1'b0;
                    end
                    if (trip_hit || kill_ev) begin
                        wait_start_q <= 1'b0;
                    end else if (latch_q && cmd_status_read[c]) begin
                        wait_start_q <= 1'b1;
                    end else if (host_clear || !latch_q) begin
                        wait_start_q <= 1'b0;
                    end
                end
            end

            // panel switches override the software state
            always_comb begin
                if (man_s[c]) begin
                    target = pot;
                end else if (run_q) begin
                    target = set_q;
                end else begin
                    target = '0;
                end
                if (target > vlim_q) begin
                    target = vlim_q;
                end
            end

            assign hold_zero = !pol_s[c] || !on_s[c] || latch_q || inh_now;
            assign load_en = 1'b0;
            assign rate_cps = man_s[c] ? 20'(HW_RAMP_V_PER_S) : {12'h000, rate_q};

            hv_ramp #(.CLK_FREQ_HZ(CLK_FREQ_HZ), .RATE_W(20)) u_ramp (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .target(target),
                .rate_cps(rate_cps),
                .hold_zero(hold_zero),
                .load_en(load_en),
                .load_val(set_q),
                .level(lvl),
                .rising(ramp_up[c]),
                .falling(ramp_down[c])
            );

            assign level_all[c*CODE_W +: CODE_W] = lvl;
            assign latched_off[c] = latch_q;
            assign trip_seen[c] = trip_flag_q;
            assign inhibit_seen[c] = inh_flag_q;
            assign error_led[c] = over_i || over_v || ((man_s[c] ? pot : set_q) > vlim_q);
            assign auto_start_read[c*4 +: 4] = auto_q ? AUTO_ON_CODE : AUTO_OFF_CODE;
            assign trip_read[c*TRIP_W +: TRIP_W] = trip_q;
            assign rate_read[c*8 +: 8] = rate_q;
        end
    endgenerate

    logic [NCH*CODE_W-1:0] dac_q;
    logic [CODE_W-1:0] disp_q;
    logic [$clog2(NCH+1)-1:0] dsel;
    assign dsel = ($clog2(NCH+1))'(chan_s);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dac_q <= '0;
        end else begin
            dac_q <= level_all;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            disp_q <= '0;
        end else if (meas_s) begin
            disp_q <= meas_current[dsel*CODE_W +: CODE_W];
        end else begin
            disp_q <= meas_voltage[dsel*CODE_W +: CODE_W];
        end
    end

    assign dac_code = dac_q;
    assign display_value = disp_q;
endmodule
`default_nettype wire

// *** core/hv_prot_pkg.sv ***
// shared constants for the high-voltage output protection and control block
// assumes a 250 MHz system clock and 16-bit setpoint codes
`default_nettype none
package hv_prot_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned CODE_W = 16;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned SEL_FULL = 10;
    localparam int unsigned HW_RAMP_V_PER_S = 500;
    localparam int unsigned SW_RAMP_MIN = 2;
    localparam int unsigned SW_RAMP_MAX = 255;
    localparam int unsigned TRIP_W = 14;
    localparam logic [13:0] TRIP_OFF = 14'h0000;
    localparam logic [13:0] TRIP_MIN = 14'h000a;
    localparam logic [13:0] TRIP_MAX = 14'h2706;
    localparam logic [3:0] AUTO_ON_CODE = 4'h8;
    localparam logic [3:0] AUTO_OFF_CODE = 4'h0;
    localparam logic [7:0] RAMP_RST = 8'h02;
    localparam int unsigned LIMIT_SCAN_HZ = 10;
    localparam int unsigned LIMIT_SCAN_CYC = CLK_HZ / LIMIT_SCAN_HZ;
    typedef enum logic [1:0] {
        MEAS_VOLT,
        MEAS_CURR
    } meas_sel_type;
endpackage
`default_nettype wire

// *** core/hv_ramp.sv ***
// ramp generator: moves a 16-bit output code toward a target at a rate
// assumes rate_cps is codes per second; step ticks from a phase accumulator
`default_nettype none
module hv_ramp
    import hv_prot_pkg::*;
#(
    parameter int unsigned CLK_FREQ_HZ = CLK_HZ,
    parameter int unsigned RATE_W = 20
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [CODE_W-1:0] target,
    input wire logic [RATE_W-1:0] rate_cps,
    input wire logic hold_zero,
    input wire logic load_en,
    input wire logic [CODE_W-1:0] load_val,
    output logic [CODE_W-1:0] level,
    output logic rising,
    output logic falling
);
    localparam logic [31:0] ACC_WRAP = 32'(CLK_FREQ_HZ);
    logic [31:0] acc_q;
    logic [CODE_W-1:0] level_q;
    logic tick;
    logic [32:0] acc_sum;

    assign acc_sum = {1'b0, acc_q} + {13'h0000, rate_cps};
    assign tick = acc_sum >= {1'b0, ACC_WRAP};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_q <= 32'h0000_0000;
        end else if (tick) begin
            acc_q <= 32'(acc_sum - {1'b0, ACC_WRAP});
        end else begin
            acc_q <= acc_sum[31:0];
        end
    end

    // hold_zero drops the level at once, without ramp
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level_q <= '0;
        end else if (hold_zero) begin
            level_q <= '0;
        end else if (load_en) begin
            level_q <= load_val;
        end else if (tick && level_q < target) begin
            level_q <= level_q + 16'h0001;
        end else if (tick && level_q > target) begin
            level_q <= level_q - 16'h0001;
        end
    end

    assign level = level_q;
    assign rising = level_q < target;
    assign falling = level_q > target;
endmodule
`default_nettype wire

// *** core/sync2.sv ***
// two flip-flop synchroniser for a bundle of asynchronous levels
// assumes inputs are quasi-static levels from pins
`default_nettype none
module sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule
`default_nettype wire

// *** verif/hv_host_model.sv ***
// host side: issues one-cycle per-channel command strobes
// assumes commands are sampled on the rising edge of sys_clk
`default_nettype none
module hv_host_model (
    input wire logic sys_clk,
    output logic [1:0] cmd_set_voltage,
    output logic [1:0] cmd_set_rate,
    output logic [1:0] cmd_set_trip,
    output logic [1:0] cmd_set_auto,
    output logic [1:0] cmd_status_read,
    output logic [1:0] cmd_start,
    output logic [1:0] cmd_output_zero,
    output logic [15:0] cmd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] stb_q = 14'h0000;
    initial cmd_data = 16'h0000;
    assign {cmd_output_zero, cmd_start, cmd_status_read, cmd_set_auto} = stb_q[13:6];
    assign {cmd_set_trip, cmd_set_rate, cmd_set_voltage} = stb_q[5:0];
    // kind: 0 voltage, 1 rate, 2 trip, 3 auto, 4 status, 5 start, 6 zero
    task automatic send(input int kind, input int ch, input logic [15:0] data);
        @(posedge sys_clk);
        cmd_data <= data;
        stb_q[kind*2 +: 2] <= 2'b01 << ch;
        @(posedge sys_clk);
        stb_q <= 14'h0000;
        @(posedge sys_clk);
    endtask
    // restart after a latch: status read must come before the start
    task automatic restart(input int ch);
        send(4, ch, 16'h0000);
        send(5, ch, 16'h0000);
    endtask
endmodule
`default_nettype wire

// *** verif/hv_prot_asserts.sv ***
// port assertions for the protection block, channel 0 watched
// assumes binding onto hv_output_protection_control
`default_nettype none
module hv_prot_asserts
    import hv_prot_pkg::*;
#(
    parameter int unsigned NCH = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [NCH-1:0] pol_at_end,
    input wire logic [NCH-1:0] shutdown_n,
    input wire logic [NCH-1:0] manual_sel,
    input wire logic [NCH-1:0] cmd_set_rate,
    input wire logic [NCH*CODE_W-1:0] meas_current,
    input wire logic [NCH*CODE_W-1:0] dac_code,
    input wire logic [NCH-1:0] latched_off,
    input wire logic [NCH*4-1:0] auto_start_read,
    input wire logic [NCH*TRIP_W-1:0] trip_read,
    input wire logic [NCH*8-1:0] rate_read
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [CODE_W-1:0] dac0;
    assign dac0 = dac_code[CODE_W-1:0];
    a_trip_latches: assert property ((trip_read[TRIP_W-1:0] != TRIP_OFF) &&
        (meas_current[CODE_W-1:0] > trip_read[TRIP_W-1:0]) |-> ##[1:3] latched_off[0])
        else $error("trip did not latch the output off");
    a_latch_zeroes: assert property (latched_off[0] |-> ##[1:2] dac0 == 16'h0000)
        else $error("latched channel still drives a code");
    a_polarity_zero: assert property (!pol_at_end[0] [*6] |-> dac0 == 16'h0000)
        else $error("polarity between ends but output nonzero");
    a_inhibit_zero: assert property (!shutdown_n[0] [*6] |-> dac0 == 16'h0000)
        else $error("shutdown input low but output nonzero");
    // a step larger than one count, other than a drop to zero, means the ramp was bypassed
    a_ramp_step: assert property (!$stable(dac0) |-> dac0 == 16'h0000 ||
        dac0 == $past(dac0) + 16'h0001 || dac0 == $past(dac0) - 16'h0001)
        else $error("output code jumped");
    a_auto_code: assert property (auto_start_read[3:0] == AUTO_ON_CODE ||
        auto_start_read[3:0] == AUTO_OFF_CODE)
        else $error("auto start read not 8 or 0");
    a_rate_range: assert property (rate_read[7:0] >= 8'h02)
        else $error("ramp rate below minimum");
    a_trip_range: assert property (trip_read[TRIP_W-1:0] <= TRIP_MAX)
        else $error("trip value above maximum");
    a_manual_hold: assert property (manual_sel[0] [*4] ##0 cmd_set_rate[0] |=> $stable(rate_read[7:0]))
        else $error("write changed rate in manual mode");
    c_latch: cover property (latched_off[0]);
    c_inhibit: cover property (!shutdown_n[0] [*6]);
    c_auto: cover property (auto_start_read[3:0] == AUTO_ON_CODE);
    c_manual: cover property (manual_sel[0] [*4] ##0 cmd_set_rate[0]);
endmodule
`default_nettype wire

// *** verif/test_hv_output_protection_control.sv ***
// top bench: drives panel pins, host commands, compares against a reference model
// assumes a 250 MHz clock, a short limit scan period and a scaled-down ramp timebase
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module test_hv_output_protection_control
    import hv_prot_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 2;
    localparam int FS = 3000;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] on_sw = 2'b11, man = 2'b00, kill = 2'b00, shut_n = 2'b11, pol = 2'b11;
    logic [7:0] vsel = 8'haa, isel = 8'haa;
    logic [31:0] pot = 32'h0000_0000, mv = 32'h0000_0000, mc = 32'h0000_0000;
    logic meas_sw = 1'b0, chan_sw = 1'b0;
    logic [1:0] c_v, c_r, c_t, c_a, c_s, c_g, c_z;
    logic [15:0] c_d;
    logic [31:0] dac;
    logic [1:0] lat, trp, err_led, inh, rup, rdn;
    logic [7:0] auto_rd;
    logic [27:0] trip_rd;
    logic [15:0] rate_rd, disp;
    logic [31:0] seed = 32'h0001_4ace;
    int err_count = 0;
    int n_tests = 0;
    int m_rate[2] = '{2, 2};
    int m_trip[2] = '{0, 0};
    int m_auto[2] = '{0, 0};
    int vals[$] = '{0, 2, 10, 100, 255, 256, 9990, 9991, 65535};
    int lim;
    initial forever #2 sys_clk = ~sys_clk;
    hv_host_model i_hv_host_model (.sys_clk(sys_clk), .cmd_set_voltage(c_v), .cmd_set_rate(c_r),
        .cmd_set_trip(c_t), .cmd_set_auto(c_a), .cmd_status_read(c_s), .cmd_start(c_g),
        .cmd_output_zero(c_z), .cmd_data(c_d));
    hv_output_protection_control #(.NCH(NCH), .LIMIT_SCAN(16), .CLK_FREQ_HZ(2000))
        i_hv_output_protection_control (
        .sys_clk(sys_clk), .rst_n(rst_n), .output_on_switch(on_sw), .manual_sel(man),
        .kill_enable(kill), .shutdown_n(shut_n), .pol_at_end(pol), .voltage_limit_selector(vsel),
        .current_limit_selector(isel), .pot_setpoint(pot), .meas_voltage(mv), .meas_current(mc),
        .meas_switch(meas_sw), .chan_switch(chan_sw), .stored_auto_start(1'b0),
        .cmd_set_voltage(c_v), .cmd_set_rate(c_r), .cmd_set_trip(c_t), .cmd_set_auto(c_a),
        .cmd_status_read(c_s), .cmd_start(c_g), .cmd_output_zero(c_z), .cmd_data(c_d),
        .dac_code(dac), .latched_off(lat), .trip_seen(trp), .error_led(err_led),
        .inhibit_seen(inh), .ramp_up(rup), .ramp_down(rdn), .auto_start_read(auto_rd),
        .trip_read(trip_rd), .rate_read(rate_rd), .display_value(disp));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // host write mirrored into the model; manual mode leaves the model untouched
    task automatic wr(input int kind, input int ch, input int d);
        i_hv_host_model.send(kind, ch, 16'(d));
        if (man[ch] == 1'b0) begin
            case (kind)
                1: m_rate[ch] = d < 2 ? 2 : (d > 255 ? 255 : d);
                2: m_trip[ch] = d > 9990 ? 9990 : d;
                3: m_auto[ch] = d != 0 ? 8 : 0;
                default: ;
            endcase
        end
        for (int c = 0; c < 2; c++) begin
            `CHK("rate", 8'(m_rate[c]), rate_rd[c*8 +: 8])
            `CHK("trip", 14'(m_trip[c]), trip_rd[c*14 +: 14])
            `CHK("auto", 4'(m_auto[c]), auto_rd[c*4 +: 4])
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        err_count++;
        end_sim();
    end
    initial begin
        pot <= xs(seed);
        cyc(16);
        rst_n <= 1'b1;
        cyc(4);
        `CHK("dac", 16'h0000, dac[15:0])
        `CHK("rup", 2'b00, rup)
        `CHK("rate0", 16'h0202, rate_rd)
        for (int i = 0; i < 8; i++) begin
            if (i < 3) begin
                lim = FS * (i * 4 + 1) / 10;
                vsel[3:0] <= 4'(i * 4 + 1);
                cyc(50);
                mv[15:0] <= 16'(lim + 1);
                cyc(3);
                `CHK("err_hi", 1'b1, err_led[0])
                mv[15:0] <= 16'(lim - 1);
                cyc(3);
                `CHK("err_lo", 1'b0, err_led[0])
            end
        end
        vsel <= 8'haa;
        cyc(50);
        foreach (vals[i]) begin
            wr(1, 0, vals[i]);
            wr(3, 0, vals[i]);
            if (vals[i] == 0 || vals[i] >= 10) wr(2, 0, vals[i]);
        end
        repeat (6) begin
            seed = xs(seed);
            wr(int'(seed[1:0]) % 3 + 1, int'(seed[2]), int'(seed[31:16] | 16'h0010));
        end
        wr(3, 0, 0);
        wr(2, 1, 0);
        man[0] <= 1'b1;
        cyc(4);
        wr(1, 0, 77);
        man[0] <= 1'b0;
        cyc(4);
        wr(1, 0, 255);
        wr(0, 0, 1000);
        wr(5, 0, 0);
        `CHK("run", 1'b1, rup[0])
        cyc(20);
        wr(6, 0, 0);
        cyc(2);
        `CHK("zero", 1'b0, rup[0])
        `CHK("zero_dn", 1'b1, rdn[0])
        wr(5, 0, 0);
        wr(2, 0, 100);
        mc[15:0] <= 16'd101;
        cyc(4);
        `CHK("trip_lat", 2'b01, lat)
        `CHK("trip_flag", 1'b1, trp[0])
        mc[15:0] <= 16'd0;
        wr(5, 0, 0);
        `CHK("no_restart", 1'b1, lat[0])
        `CHK("trip_dac", 16'h0000, dac[15:0])
        i_hv_host_model.restart(0);
        `CHK("restart", 1'b0, lat[0])
        wr(3, 0, 1);
        mc[15:0] <= 16'd101;
        cyc(4);
        mc[15:0] <= 16'd0;
        wr(4, 0, 0);
        cyc(2);
        `CHK("auto_restart", 1'b0, lat[0])
        wr(3, 0, 0);
        for (int m = 0; m < 2; m++) begin
            kill[0] <= 1'b1;
            cyc(4);
            shut_n[0] <= 1'b0;
            pol[0] <= 1'b0;
            cyc(8);
            shut_n[0] <= 1'b1;
            pol[0] <= 1'b1;
            cyc(4);
            `CHK("kill_lat", 1'b1, lat[0])
            `CHK("kill_inh", 1'b1, inh[0])
            if (m == 0) kill[0] <= 1'b0;
            else on_sw[0] <= 1'b0;
            cyc(4);
            on_sw[0] <= 1'b1;
            cyc(4);
            `CHK("kill_clr", 1'b0, lat[0])
        end
        kill[0] <= 1'b0;
        wr(5, 0, 0);
        shut_n[0] <= 1'b0;
        cyc(8);
        `CHK("inh_lat", 1'b0, lat[0])
        `CHK("inh_dac", 16'h0000, dac[15:0])
        shut_n[0] <= 1'b1;
        cyc(5);
        `CHK("inh_back", 1'b1, rup[0])
        mv <= xs(seed);
        mc <= ~xs(seed);
        for (int k = 0; k < 4; k++) begin
            meas_sw <= k[0];
            chan_sw <= k[1];
            cyc(5);
            `CHK("disp", k[0] ? mc[k[1]*16 +: 16] : mv[k[1]*16 +: 16], disp)
        end
        end_sim();
    end
endmodule
bind hv_output_protection_control hv_prot_asserts #(.NCH(NCH)) i_hv_prot_asserts (.sys_clk(sys_clk),
    .rst_n(rst_n), .pol_at_end(pol_at_end), .shutdown_n(shutdown_n), .manual_sel(manual_sel),
    .cmd_set_rate(cmd_set_rate), .meas_current(meas_current), .dac_code(dac_code),
    .latched_off(latched_off), .auto_start_read(auto_start_read), .trip_read(trip_read),
    .rate_read(rate_read));
`default_nettype wire
